// *** rtl/cfg_pkg.sv ***
// constants shared by the configuration loader and its bus controller
// assumes one 100 MHz clock and a synchronous active-high reset
package cfg_pkg;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int unsigned CLK_NS = 10;
    localparam int unsigned DL_DELAY_NS = 500000;
    localparam int unsigned DL_DELAY_CYC = DL_DELAY_NS / CLK_NS;
    localparam int unsigned FETCH_NS = 10000;
    localparam int unsigned FETCH_CYC = FETCH_NS / CLK_NS;
    // ----------------------------------------
    // register pointer map of the device
    // ----------------------------------------
    localparam int unsigned N_DAC = 6;
    localparam int unsigned N_CFG = 18;
    localparam logic [7:0] A_DAC = 8'h00;
    localparam logic [7:0] A_LOW = 8'h06;
    localparam logic [7:0] A_HIGH = 8'h0c;
    localparam logic [7:0] A_NV = 8'h20;
    localparam logic [7:0] A_UPD = 8'h90;
    localparam logic [7:0] A_ERASE = 8'hd4;
    localparam logic [7:0] A_USER_DL = 8'hd8;
    localparam logic [7:0] A_SE_SEL = 8'he0;
    localparam logic [7:0] A_SE_BUF = 8'he8;
    localparam logic [7:0] UPD_RESET = 8'h00;
    localparam int unsigned UPD_TRANSP = 0;
    localparam int unsigned UPD_COMMIT = 1;
    localparam int unsigned UPD_ERASE_EN = 2;
    localparam int unsigned USER_DL_BIT = 0;
    localparam int unsigned ERASE_SE = 7;
    localparam logic [5:0] SE_LAST = 6'h3e;
    // ----------------------------------------
    // link phase kinds
    // ----------------------------------------
    localparam logic [1:0] K_PTR = 2'h0;
    localparam logic [1:0] K_WR = 2'h1;
    localparam logic [1:0] K_RD = 2'h2;
    // ----------------------------------------
    // controller registers over axi4-lite
    // ----------------------------------------
    localparam logic [3:0] R_CMD = 4'h0;
    localparam logic [3:0] R_STAT = 4'h4;
    localparam int unsigned CMD_RD = 16;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** rtl/cfg_link_if.sv ***
// byte link between the bus controller and the configuration device
// both ends share clk; req is held until the one-cycle resp
`timescale 1ns/1ps
interface cfg_link_if;
    logic req;
    logic [1:0] kind;
    logic [7:0] wdata;
    logic resp;
    logic nack;
    logic [7:0] rdata;
    modport device (input req, input kind, input wdata, output resp, output nack, output rdata);
    modport host (output req, output kind, output wdata, input resp, input nack, input rdata);
endinterface

// *** rtl/cfg_device_end.sv ***
// configuration loader: nonvolatile store, double latches, dac clipping
// assumes supply_ok and state_met come asynchronously from outside
// Operation
// R01: dac follows code, clipped to limits
// R02: dac buffer off when low exceeds high
// R03: limit registers restored at download
// R04: each setting in two latches, a then b
// R05: download starts only above supply lockout
// R06: all a latches copy to b together
// R07: first state fetched 0.5 ms later
// R08: nack all accesses until download done
// R09: transparent bit writes both latches
// R10: otherwise only a changes until commit
// R11: commit write pulses every b load
// R12: nonvolatile edits leave running setup alone
// R13: nonvolatile writes staged like volatile ones
// R14: erase only when erase enable set
// R15: sequencer store 63 words of 64 bits
// R16: next state fetched when conditions met
// R17: state words written straight to store; code stages them until commit unless transparent bit set
// R18: first write byte sets address pointer
// R19: accesses go where pointer points
// R20: user download reloads like power-up
// R21: commit bit self-clears, reads zero
`timescale 1ns/1ps
module cfg_device_end #(
    parameter int unsigned DL_DELAY_CYC = cfg_pkg::DL_DELAY_CYC
) (
    input wire logic clk, // 100 MHz
    input wire logic reset, // sync, active high
    input wire logic supply_ok, // supply above lockout, async
    input wire logic state_met, // sequencer conditions met, async
    cfg_link_if.device lnk, // byte link to the controller
    output logic [47:0] dac_drive, // clipped codes, six bytes
    output logic [5:0] dac_hiz, // dac buffer off per channel
    output logic [63:0] se_word, // active state definition
    output logic [5:0] se_index, // active state number
    output logic dl_done // configuration download finished
);
    typedef enum logic [2:0] {S_LOCK, S_LOAD, S_XFER, S_WAIT, S_FETCH, S_RUN} pwr_e;
    localparam int unsigned NC = cfg_pkg::N_CFG;
    localparam int unsigned ND = cfg_pkg::N_DAC;

    pwr_e st_ff, nxt_st;
    logic sup_m_ff, sup_ff, met_m_ff, met_ff, met_q_ff;
    logic [7:0] lat_a_ff [NC];
    logic [7:0] lat_b_ff [NC];
    logic [7:0] nv_cfg [NC];
    logic [7:0] nv_stage_ff [NC];
    logic [NC-1:0] nv_dirty_ff;
    logic [63:0] se_nv [64];
    logic [7:0] se_buf_ff [8];
    logic [5:0] se_sel_ff;
    logic se_pend_ff;
    logic [2:0] upd_ff;
    logic [7:0] ptr_ff;
    logic [4:0] idx_ff;
    logic [15:0] cnt_ff;
    logic resp_ff, nack_ff, done_ff;
    logic [7:0] rdata_ff;
    logic [47:0] drive_ff;
    logic [5:0] hiz_ff;
    logic [63:0] word_ff;
    logic [5:0] sidx_ff;

    // ----------------------------------------
    // link decode
    // ----------------------------------------
    wire take = lnk.req && !resp_ff;
    wire busy = !done_ff || st_ff == S_LOAD || st_ff == S_XFER; // R08
    wire acc = take && !busy;
    wire set_ptr = acc && lnk.kind == cfg_pkg::K_PTR; // R18
    wire wr = acc && lnk.kind == cfg_pkg::K_WR;
    wire transp = upd_ff[cfg_pkg::UPD_TRANSP];
    wire [7:0] nv_off = ptr_ff - cfg_pkg::A_NV;
    wire cfg_hit = ptr_ff < 8'(NC); // R19
    wire nv_hit = ptr_ff >= cfg_pkg::A_NV && nv_off < 8'(NC);
    wire buf_hit = ptr_ff[7:3] == cfg_pkg::A_SE_BUF[7:3];
    wire [4:0] ci = ptr_ff[4:0];
    wire [4:0] ni = nv_off[4:0];
    wire [2:0] bi = ptr_ff[2:0];
    wire wr_cfg = wr && cfg_hit;
    wire wr_nv = wr && nv_hit;
    wire wr_upd = wr && ptr_ff == cfg_pkg::A_UPD;
    wire commit = wr_upd && lnk.wdata[cfg_pkg::UPD_COMMIT]; // R11 R21
    wire erase = wr && ptr_ff == cfg_pkg::A_ERASE && upd_ff[cfg_pkg::UPD_ERASE_EN]; // R14
    wire user_dl = wr && ptr_ff == cfg_pkg::A_USER_DL
        && lnk.wdata[cfg_pkg::USER_DL_BIT] && st_ff == S_RUN; // R20
    wire se_prog = wr && buf_hit && bi == 3'h7; // R17
    wire [63:0] se_new = {lnk.wdata, se_buf_ff[6], se_buf_ff[5], se_buf_ff[4],
        se_buf_ff[3], se_buf_ff[2], se_buf_ff[1], se_buf_ff[0]};
    wire met_rise = met_ff && !met_q_ff;
    wire [7:0] rd_mux = cfg_hit ? lat_a_ff[ci]
        : nv_hit ? nv_cfg[ni]
        : ptr_ff == cfg_pkg::A_UPD ? {5'h00, upd_ff[2], 1'b0, upd_ff[0]} // R21
        : ptr_ff == cfg_pkg::A_SE_SEL ? {2'h0, se_sel_ff}
        : buf_hit ? se_buf_ff[bi] : 8'h00;

    // ----------------------------------------
    // power-up and download sequence
    // ----------------------------------------
    always_comb begin
        nxt_st = st_ff;
        unique case (st_ff)
            S_LOCK: if (sup_ff) nxt_st = S_LOAD; // R05
            S_LOAD: if (idx_ff == 5'(NC - 1)) nxt_st = S_XFER;
            S_XFER: nxt_st = done_ff ? S_RUN : S_WAIT; // R06
            S_WAIT: if (cnt_ff == 16'(DL_DELAY_CYC - 1)) nxt_st = S_FETCH; // R07
            S_FETCH: if (cnt_ff == 16'(cfg_pkg::FETCH_CYC - 1)) nxt_st = S_RUN; // R16
            S_RUN: begin
                if (user_dl) nxt_st = S_LOAD; // R20
                else if (met_rise) nxt_st = S_FETCH; // R16
            end
        endcase
    end

    always_ff @(posedge clk) begin
        sup_m_ff <= supply_ok;
        sup_ff <= sup_m_ff;
        met_m_ff <= state_met;
        met_ff <= met_m_ff;
        met_q_ff <= met_ff;
        if (reset) begin
            st_ff <= S_LOCK;
            idx_ff <= 5'h00;
            cnt_ff <= 16'h0000;
            done_ff <= 1'b0;
            sidx_ff <= 6'h00;
            word_ff <= 64'h0;
        end else begin
            st_ff <= nxt_st;
            idx_ff <= st_ff == S_LOAD ? idx_ff + 5'h01 : 5'h00;
            cnt_ff <= nxt_st == st_ff && (st_ff == S_WAIT || st_ff == S_FETCH)
                ? cnt_ff + 16'h0001 : 16'h0000;
            if (st_ff == S_XFER) done_ff <= 1'b1;
            if (st_ff == S_RUN && met_rise)
                sidx_ff <= sidx_ff == cfg_pkg::SE_LAST ? 6'h00 : sidx_ff + 6'h01; // R15
            if (st_ff == S_FETCH && nxt_st == S_RUN) word_ff <= se_nv[sidx_ff]; // R16
        end
    end

    // ----------------------------------------
    // double latches
    // ----------------------------------------
    // operating copy (b) only moves on transfer, transparent write or commit
    always_ff @(posedge clk) begin
        for (int i = 0; i < NC; i++) begin
            if (reset) begin
                lat_a_ff[i] <= 8'h00;
                lat_b_ff[i] <= 8'h00;
            end else begin
                if (st_ff == S_LOAD && idx_ff == 5'(i)) lat_a_ff[i] <= nv_cfg[i]; // R03 R04
                else if (wr_cfg && ci == 5'(i)) lat_a_ff[i] <= lnk.wdata; // R10
                if (st_ff == S_XFER || commit) lat_b_ff[i] <= lat_a_ff[i]; // R06 R11
                else if (wr_cfg && ci == 5'(i) && transp) lat_b_ff[i] <= lnk.wdata; // R09
            end
        end
    end

    // ----------------------------------------
    // nonvolatile stores
    // ----------------------------------------
    // contents survive reset on purpose; edits never touch the latches
    always_ff @(posedge clk) begin
        for (int i = 0; i < NC; i++) begin
            if (erase && !lnk.wdata[cfg_pkg::ERASE_SE]) nv_cfg[i] <= 8'hff; // R14
            else if (wr_nv && ni == 5'(i) && transp) nv_cfg[i] <= lnk.wdata; // R12
            else if (commit && nv_dirty_ff[i]) nv_cfg[i] <= nv_stage_ff[i]; // R13
        end
        if (erase && lnk.wdata[cfg_pkg::ERASE_SE]) se_nv[lnk.wdata[5:0]] <= '1; // R14
        else if (se_prog && transp) se_nv[se_sel_ff] <= se_new; // R17
        else if (commit && se_pend_ff) se_nv[se_sel_ff] <= {se_buf_ff[7], se_buf_ff[6],
            se_buf_ff[5], se_buf_ff[4], se_buf_ff[3], se_buf_ff[2], se_buf_ff[1],
            se_buf_ff[0]}; // R13
    end

    always_ff @(posedge clk) begin
        for (int i = 0; i < NC; i++) begin
            if (wr_nv && ni == 5'(i)) nv_stage_ff[i] <= lnk.wdata;
        end
        for (int j = 0; j < 8; j++) begin
            if (wr && buf_hit && bi == 3'(j)) se_buf_ff[j] <= lnk.wdata;
        end
        if (reset) begin
            nv_dirty_ff <= '0;
            se_pend_ff <= 1'b0;
            se_sel_ff <= 6'h00;
            upd_ff <= cfg_pkg::UPD_RESET[2:0];
            ptr_ff <= 8'h00;
        end else begin
            for (int i = 0; i < NC; i++) begin
                if (wr_nv && ni == 5'(i) && !transp) nv_dirty_ff[i] <= 1'b1; // R13
                else if (commit) nv_dirty_ff[i] <= 1'b0;
            end
            if (se_prog && !transp) se_pend_ff <= 1'b1;
            else if (commit) se_pend_ff <= 1'b0;
            if (wr && ptr_ff == cfg_pkg::A_SE_SEL) se_sel_ff <= lnk.wdata[5:0];
            if (wr_upd) upd_ff <= {lnk.wdata[2], 1'b0, lnk.wdata[0]}; // R21
            if (set_ptr) ptr_ff <= lnk.wdata; // R18
        end
    end

    // ----------------------------------------
    // link answer
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            resp_ff <= 1'b0;
            nack_ff <= 1'b0;
            rdata_ff <= 8'h00;
        end else begin
            resp_ff <= take;
            if (take) nack_ff <= busy; // R08
            if (acc && lnk.kind == cfg_pkg::K_RD) rdata_ff <= rd_mux; // R19
        end
    end

    // ----------------------------------------
    // dac clipping
    // ----------------------------------------
    wire [47:0] clip_all;
    wire [5:0] off_all;
    for (genvar c = 0; c < ND; c++) begin : g_dac
        wire [7:0] code = lat_b_ff[c];
        wire [7:0] lo = lat_b_ff[c + ND];
        wire [7:0] hi = lat_b_ff[c + 2 * ND];
        assign clip_all[c*8 +: 8] = code < lo ? lo : code > hi ? hi : code; // R01
        assign off_all[c] = lo > hi; // R02
    end

    // one process owns both output registers, so no slice has two writers
    always_ff @(posedge clk) begin
        if (reset) begin
            drive_ff <= 48'h0;
            hiz_ff <= 6'h3f;
        end else begin
            drive_ff <= clip_all;
            hiz_ff <= off_all;
        end
    end

    assign lnk.resp = resp_ff;
    assign lnk.nack = nack_ff;
    assign lnk.rdata = rdata_ff;
    assign dac_drive = drive_ff;
    assign dac_hiz = hiz_ff;
    assign se_word = word_ff;
    assign se_index = sidx_ff;
    assign dl_done = done_ff;
endmodule

// *** rtl/cfg_host_end.sv ***
// bus controller: turns axi4-lite commands into pointer and data phases
// assumes the device answers every held request with a resp pulse
`timescale 1ns/1ps
module cfg_host_end (
    input wire logic clk, // 100 MHz
    input wire logic reset, // sync, active high
    input wire logic [3:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // byte enables
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [3:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    cfg_link_if.host lnk // byte link to the device
);
    typedef enum logic [1:0] {H_IDLE, H_PTR, H_DATA} host_e;
    host_e st_ff;
    logic awr_ff, ard_ff, bv_ff, rv_ff, req_ff, nack_ff, rd_ff;
    logic [1:0] br_ff, rr_ff, kind_ff;
    logic [7:0] wd_ff, data_ff, got_ff;
    logic [31:0] rdat_ff;

    // ----------------------------------------
    // axi decode
    // ----------------------------------------
    wire aw_go = awr_ff && s_axi_awvalid && s_axi_wvalid;
    wire ar_go = ard_ff && s_axi_arvalid;
    wire cmd_hit = s_axi_awaddr == cfg_pkg::R_CMD;
    wire start = aw_go && cmd_hit && st_ff == H_IDLE && s_axi_wstrb[0];
    wire rd_map = s_axi_araddr == cfg_pkg::R_STAT || s_axi_araddr == cfg_pkg::R_CMD;
    wire [31:0] stat = {16'h0000, got_ff, 6'h00, nack_ff, st_ff != H_IDLE};
    wire done = req_ff && lnk.resp;

    always_ff @(posedge clk) begin
        if (reset) begin
            awr_ff <= 1'b0;
            ard_ff <= 1'b0;
            bv_ff <= 1'b0;
            rv_ff <= 1'b0;
            br_ff <= cfg_pkg::RESP_OK;
            rr_ff <= cfg_pkg::RESP_OK;
            rdat_ff <= 32'h0;
        end else begin
            // both channels are taken together, at the second edge after both are offered
            awr_ff <= s_axi_awvalid && s_axi_wvalid && !awr_ff && !bv_ff;
            ard_ff <= s_axi_arvalid && !ard_ff && !rv_ff;
            if (aw_go) begin
                bv_ff <= 1'b1;
                br_ff <= cmd_hit ? cfg_pkg::RESP_OK : cfg_pkg::RESP_SLVERR;
            end else if (s_axi_bready) bv_ff <= 1'b0;
            if (ar_go) begin
                rv_ff <= 1'b1;
                rr_ff <= rd_map ? cfg_pkg::RESP_OK : cfg_pkg::RESP_SLVERR;
                rdat_ff <= s_axi_araddr == cfg_pkg::R_STAT ? stat : 32'h0;
            end else if (s_axi_rready) rv_ff <= 1'b0;
        end
    end

    // ----------------------------------------
    // link sequencer
    // ----------------------------------------
    // a nack on the pointer phase ends the command; software retries later
    always_ff @(posedge clk) begin
        if (reset) begin
            st_ff <= H_IDLE;
            req_ff <= 1'b0;
            kind_ff <= cfg_pkg::K_PTR;
            wd_ff <= 8'h00;
            data_ff <= 8'h00;
            rd_ff <= 1'b0;
            nack_ff <= 1'b0;
            got_ff <= 8'h00;
        end else begin
            unique case (st_ff)
                H_IDLE: if (start) begin
                    st_ff <= H_PTR;
                    req_ff <= 1'b1;
                    kind_ff <= cfg_pkg::K_PTR; // R18
                    wd_ff <= s_axi_wdata[7:0];
                    data_ff <= s_axi_wdata[15:8];
                    rd_ff <= s_axi_wdata[cfg_pkg::CMD_RD];
                    nack_ff <= 1'b0;
                end
                H_PTR: if (done) begin
                    nack_ff <= lnk.nack; // R08
                    if (lnk.nack) begin
                        st_ff <= H_IDLE;
                        req_ff <= 1'b0;
                    end else begin
                        st_ff <= H_DATA;
                        kind_ff <= rd_ff ? cfg_pkg::K_RD : cfg_pkg::K_WR;
                        wd_ff <= data_ff;
                    end
                end
                H_DATA: if (done) begin
                    st_ff <= H_IDLE;
                    req_ff <= 1'b0;
                    nack_ff <= lnk.nack;
                    if (rd_ff) got_ff <= lnk.rdata;
                end
                default: begin
                    st_ff <= H_IDLE;
                    req_ff <= 1'b0;
                end
            endcase
        end
    end

    assign s_axi_awready = awr_ff;
    assign s_axi_wready = awr_ff;
    assign s_axi_bvalid = bv_ff;
    assign s_axi_bresp = br_ff;
    assign s_axi_arready = ard_ff;
    assign s_axi_rvalid = rv_ff;
    assign s_axi_rresp = rr_ff;
    assign s_axi_rdata = rdat_ff;
    assign lnk.req = req_ff;
    assign lnk.kind = kind_ff;
    assign lnk.wdata = wd_ff;
endmodule

// *** tb/cfg_link_props.sv ***
// assertions on the byte link between the controller and the device end
// assumes link signals and dl_done sampled on clk with a sync high reset
`timescale 1ns/1ps
module cfg_link_props (
    input wire logic clk, // clock
    input wire logic reset, // sync, high
    input wire logic req, // request
    input wire logic [1:0] kind, // phase kind
    input wire logic [7:0] wdata, // phase byte
    input wire logic resp, // answer pulse
    input wire logic nack, // refusal
    input wire logic [7:0] rdata, // read byte
    input wire logic dl_done // download done
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    chk_one_resp: assert property (resp |=> !resp) else $error("resp held");
    chk_answer_next: assert property (req && !resp |=> resp) else $error("no answer");
    chk_resp_cause: assert property (resp |-> $past(req) && !$past(resp))
        else $error("resp without request");
    chk_host_holds: assert property (req && !resp |=> req && $stable(kind) && $stable(wdata))
        else $error("request dropped early");
    chk_ptr_first: assert property ($rose(req) |-> kind == cfg_pkg::K_PTR)
        else $error("phase before pointer");
    chk_data_follows: assert property (resp && !nack && kind == cfg_pkg::K_PTR |=>
        req && kind != cfg_pkg::K_PTR) else $error("no data phase");
    chk_nack_early: assert property (resp && !dl_done |-> nack) else $error("early ack");
    chk_nack_holds: assert property (!resp && !$past(reset) |-> $stable(nack))
        else $error("nack moved");
    chk_rdata_holds: assert property (!(resp && kind == cfg_pkg::K_RD) && !$past(reset)
        |-> $stable(rdata)) else $error("rdata moved");
    chk_done_stays: assert property (dl_done |=> dl_done) else $error("done fell");
    cov_nack: cover property (resp && nack);
    cov_write: cover property (resp && !nack && kind == cfg_pkg::K_WR);
    cov_read: cover property (resp && !nack && kind == cfg_pkg::K_RD);
endmodule

// *** tb/config_download_update_ctrl_tb.sv ***
// testbench: axi4-lite commands reach the device end through the controller
// assumes both ends joined by cfg_link_if on one 100 MHz clock
`timescale 1ns/1ps
module config_download_update_ctrl_tb;
    logic clk = 1'b0, reset = 1'b1, supply_ok = 1'b0, state_met = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic awready, wready, bvalid, arready, rvalid, dl_done;
    logic [1:0] bresp, rresp, br;
    logic [31:0] rdat, st;
    logic [47:0] dac_drive;
    logic [5:0] dac_hiz, se_index;
    logic [63:0] se_word;
    int errors = 0, samples_checked = 0;
    cfg_link_if lnk();
    always #5 clk = ~clk;
    cfg_device_end #(.DL_DELAY_CYC(20)) cfg_device_end_inst (.clk(clk), .reset(reset),
        .supply_ok(supply_ok), .state_met(state_met), .lnk(lnk), .dac_drive(dac_drive),
        .dac_hiz(dac_hiz), .se_word(se_word), .se_index(se_index), .dl_done(dl_done));
    cfg_host_end cfg_host_end_inst (.clk(clk), .reset(reset), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdat), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .lnk(lnk));
    cfg_link_props cfg_link_props_inst (.clk(clk), .reset(reset), .req(lnk.req),
        .kind(lnk.kind), .wdata(lnk.wdata), .resp(lnk.resp), .nack(lnk.nack),
        .rdata(lnk.rdata), .dl_done(dl_done));
    task automatic stop_test;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic give_up;
        errors++;
        stop_test();
    endtask
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("mismatch at %0t got %h exp %h", $time, g, e);
        end
    endtask
    // sampled at the falling edge so the reading never races the design
    task automatic wait_hi(ref logic s);
        int n = 0;
        do @(negedge clk); while (s !== 1'b1 && ++n < 2000);
        if (n >= 2000) give_up();
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        awaddr <= a;
        wdat <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        wait_hi(awready);
        @(posedge clk);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        bready <= 1'b1;
        wait_hi(bvalid);
        br = bresp;
        @(posedge clk);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        wait_hi(arready);
        @(posedge clk);
        arvalid <= 1'b0;
        rready <= 1'b1;
        wait_hi(rvalid);
        st = rdat;
        @(posedge clk);
        rready <= 1'b0;
    endtask
    task automatic cmd(input logic [7:0] p, input logic [7:0] d, input logic r);
        int n = 0;
        wr(cfg_pkg::R_CMD, {15'h0, r, d, p});
        do rd(cfg_pkg::R_STAT); while (st[0] !== 1'b0 && ++n < 40);
        if (n >= 40) give_up();
    endtask
    task automatic t_early;
        cmd(cfg_pkg::A_UPD, 8'h01, 1'b0);
        chk(st[1], 1'b1);
        chk(dl_done, 1'b0);
        wr(4'h8, 32'h0);
        chk(br, cfg_pkg::RESP_SLVERR);
        supply_ok <= 1'b1;
        wait_hi(dl_done);
        // user download is only taken once the power-up fetch has ended
        repeat (cfg_pkg::FETCH_CYC + 40) @(posedge clk);
        cmd(cfg_pkg::A_UPD, 8'h01, 1'b0);
        chk(st[1], 1'b0);
    endtask
    task automatic t_dac;
        logic [7:0] code [5] = '{8'h1f, 8'hc1, 8'h80, 8'h20, 8'hc0};
        logic [7:0] want [5] = '{8'h20, 8'hc0, 8'h80, 8'h20, 8'hc0};
        cmd(cfg_pkg::A_HIGH, 8'hc0, 1'b0);
        cmd(cfg_pkg::A_LOW, 8'hc1, 1'b0);
        chk(dac_hiz[0], 1'b1);
        cmd(cfg_pkg::A_LOW, 8'h20, 1'b0);
        chk(dac_hiz[0], 1'b0);
        for (int i = 0; i < 5; i++) begin
            cmd(cfg_pkg::A_DAC, code[i], 1'b0);
            chk(dac_drive[7:0], want[i]);
        end
    endtask
    task automatic t_staged;
        cmd(cfg_pkg::A_UPD, 8'h00, 1'b0);
        cmd(cfg_pkg::A_DAC, 8'h50, 1'b0);
        chk(dac_drive[7:0], 8'hc0);
        cmd(cfg_pkg::A_DAC, 8'h00, 1'b1);
        chk(st[15:8], 8'h50);
        cmd(cfg_pkg::A_UPD, 8'h02, 1'b0);
        chk(dac_drive[7:0], 8'h50);
        cmd(cfg_pkg::A_UPD, 8'h00, 1'b1);
        chk(st[15:8], 8'h00);
    endtask
    // link nacks while the reload runs, so poll until a read is accepted
    task automatic reload;
        int n = 0;
        cmd(cfg_pkg::A_USER_DL, 8'h01, 1'b0);
        do cmd(cfg_pkg::A_DAC, 8'h00, 1'b1); while (st[1] !== 1'b0 && ++n < 40);
        if (n >= 40) give_up();
    endtask
    task automatic t_nv;
        for (int i = 0; i < 18; i++) begin
            cmd(cfg_pkg::A_NV + 8'(i), i < 6 ? 8'h60 : (i < 12 ? 8'h10 : 8'hf0), 1'b0);
        end
        cmd(cfg_pkg::A_UPD, 8'h02, 1'b0);
        chk(dac_drive[7:0], 8'h50);
        reload();
        chk(dac_drive, {6{8'h60}});
        chk(dac_hiz, 6'h00);
        cmd(cfg_pkg::A_UPD, 8'h01, 1'b0);
        cmd(cfg_pkg::A_ERASE, 8'h00, 1'b0);
        reload();
        chk(dac_drive, {6{8'h60}});
        cmd(cfg_pkg::A_UPD, 8'h05, 1'b0);
        cmd(cfg_pkg::A_ERASE, 8'h00, 1'b0);
        reload();
        chk(dac_drive, {6{8'hff}});
    endtask
    task automatic t_seq;
        int n = 0;
        cmd(cfg_pkg::A_SE_SEL, 8'h01, 1'b0);
        for (int b = 0; b < 8; b++) begin
            cmd(cfg_pkg::A_SE_BUF + 8'(b), 8'(8'h11 * (b + 1)), 1'b0);
        end
        repeat (1100) @(posedge clk);
        state_met <= 1'b1;
        // the index steps at the edge, the word only when the fetch ends
        do @(negedge clk); while (se_word !== 64'h8877665544332211 && ++n < 1200);
        @(posedge clk);
        state_met <= 1'b0;
        chk(se_word, 64'h8877665544332211);
        chk(se_index, 6'h01);
        chk(n > 995 && n < 1010, 1'b1);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        t_early();
        t_dac();
        t_staged();
        t_nv();
        t_seq();
        stop_test();
    end
endmodule
